// File: hdl/ewsg_top.sv
`include "ewsg_regs.svh"
`default_nettype none
module ewsg_top (
   input wire logic mclk, // Processor clock, 10 MHz.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic [6:0] mmrAddr, // Register address.
   input wire logic mmrWr, // Register write strobe.
   input wire logic mmrRd, // Register read strobe.
   input wire logic [15:0] mmrWrData, // Register write data.
   output logic [15:0] mmrRdData, // Register read data, one cycle after the strobe.
   input wire logic accReq, // External access request.
   input wire ewsg_pkg::ewsg_space_t accSpace, // Space of the request.
   input wire logic [22:0] accAddr, // Address of the request.
   input wire logic extReady, // Ready input from the external device.
   output logic accBusy, // Access in progress.
   output logic accDone, // Access completes, one-cycle pulse.
   output logic [3:0] accWaits, // Wait states applied to the current access.
   output logic waitGenClkEn // Wait-generator clock running.
);
   import ewsg_pkg::*;

   logic [15:0] counts_r;
   logic multBit_r;
   logic [15:0] rdData_r;
   ewsg_state_t state_r;
   ewsg_state_t state_nxt;
   logic busy_r;
   logic done_r;
   logic [3:0] waits_r;
   logic clkEn_r;

   wire hitCounts = (mmrAddr == `EWSG_ADDR_COUNTS);
   wire hitControl = (mmrAddr == `EWSG_ADDR_CONTROL);
   wire extProgSel = counts_r[`EWSG_EXTPROG_BIT];
   wire [2:0] ioBase = counts_r[`EWSG_IO_LSB +: `EWSG_FIELD_W];
   wire [2:0] dataHiBase = counts_r[`EWSG_DHI_LSB +: `EWSG_FIELD_W];
   wire [2:0] dataLoBase = counts_r[`EWSG_DLO_LSB +: `EWSG_FIELD_W];
   wire [2:0] progHiBase = counts_r[`EWSG_PHI_LSB +: `EWSG_FIELD_W];
   wire [2:0] progLoBase = counts_r[`EWSG_PLO_LSB +: `EWSG_FIELD_W];

   // Program split follows bit 15 within a page, or bit 22 of the extended address.
   wire progUpper = extProgSel ? accAddr[22] : accAddr[15];
   wire [2:0] progBase = progUpper ? progHiBase : progLoBase;
   wire [2:0] dataBase = accAddr[15] ? dataHiBase : dataLoBase;
   wire [2:0] reqBase = (accSpace == EWSG_SPACE_IO) ? ioBase :
                        (accSpace == EWSG_SPACE_DATA) ? dataBase : progBase;
   wire [3:0] reqWaits = multBit_r ? {reqBase, 1'b0} : {1'b0, reqBase};
   wire allZero = (counts_r[13:0] == 14'h0000);
   wire accept = accReq && (state_r == EWSG_ST_IDLE);
   wire cntLast;
   wire finish = (state_r == EWSG_ST_READY) && extReady;
   // An access already counting keeps its enable, so a late write of all-zero counts cannot freeze it.
   wire cntRun = clkEn_r || (state_r == EWSG_ST_WAIT);
   localparam logic [15:0] CtrlReset = `EWSG_CONTROL_RESET;

   wire [15:0] rdSel = hitCounts ? counts_r :
                       hitControl ? {15'h0000, multBit_r} : 16'h0000;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         EWSG_ST_IDLE: begin
            if (accept) begin
               state_nxt = (reqWaits == 4'h0) ? EWSG_ST_READY : EWSG_ST_WAIT;
            end
         end
         EWSG_ST_WAIT: begin
            if (cntLast) begin
               state_nxt = EWSG_ST_READY;
            end
         end
         EWSG_ST_READY: begin
            if (extReady) begin
               state_nxt = EWSG_ST_IDLE;
            end
         end
         default: state_nxt = EWSG_ST_IDLE;
      endcase
   end

   ewsg_wait_counter #(.W(4)) waitCount (
      .mclk(mclk),
      .rst_n(rst_n),
      .cntEn(cntRun),
      .load(accept),
      .loadVal(reqWaits),
      .lastOne(cntLast)
   );

   // Registers; reserved control bits are never stored, so they cannot be written.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         counts_r <= `EWSG_COUNTS_RESET;
         multBit_r <= CtrlReset[`EWSG_MULT_BIT];
         rdData_r <= 16'h0000;
      end else begin
         if (mmrWr && hitCounts) begin
            counts_r <= mmrWrData;
         end
         if (mmrWr && hitControl) begin
            multBit_r <= mmrWrData[`EWSG_MULT_BIT];
         end
         if (mmrRd) begin
            rdData_r <= rdSel;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= EWSG_ST_IDLE;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         waits_r <= 4'h0;
         clkEn_r <= 1'b1;
      end else begin
         state_r <= state_nxt;
         busy_r <= accept || (busy_r && !finish);
         done_r <= finish;
         clkEn_r <= !allZero;
         if (accept) begin
            waits_r <= reqWaits;
         end
      end
   end

   assign mmrRdData = rdData_r;
   assign accBusy = busy_r;
   assign accDone = done_r;
   assign accWaits = waits_r;
   assign waitGenClkEn = clkEn_r;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   max_waits_a: assert property (accept |=> waits_r <= `EWSG_MAX_WAITS)
      else $error("Applied wait count above fourteen.");
   ready_hold_a: assert property ((state_r == EWSG_ST_READY) && !extReady |=> !done_r && busy_r)
      else $error("Access completed without ready.");
   clk_gate_a: assert property (allZero ##1 allZero |-> !clkEn_r)
      else $error("Wait clock running with all counts zero.");
   reset_counts_a: assert property ($rose(rst_n) |-> counts_r == `EWSG_COUNTS_RESET && !multBit_r)
      else $error("Reset counts not seven everywhere.");
   io_range_a: assert property (accept && accSpace == EWSG_SPACE_IO && !multBit_r
      |=> waits_r == {1'b0, $past(ioBase)})
      else $error("I/O access used wrong count.");
   prog_ext_a: assert property (accept && accSpace == EWSG_SPACE_PROG && extProgSel && accAddr[22]
      && multBit_r |=> waits_r == {$past(progHiBase), 1'b0})
      else $error("Extended upper program access used wrong count.");
   ctrl_read_a: assert property (mmrRd && hitControl
      |=> mmrRdData == {15'h0000, $past(multBit_r)})
      else $error("Control register read wrong.");
   wait_hold_a: assert property (accept && reqWaits == 4'h2 |=> !done_r [*3] ##1 (done_r == $past(extReady)))
      else $error("Two-wait access timing wrong.");

   // Range decode: each space and half must pick its own field, whatever the others hold.
   data_lo_a: assert property (accept && (accSpace == EWSG_SPACE_DATA) && !accAddr[15] && !multBit_r
      |=> waits_r == {1'b0, $past(dataLoBase)})
      else $error("Lower data access used wrong count.");
   data_hi_a: assert property (accept && (accSpace == EWSG_SPACE_DATA) && accAddr[15] && multBit_r
      |=> waits_r == {$past(dataHiBase), 1'b0})
      else $error("Upper data access used wrong count.");
   prog_page_a: assert property (accept && (accSpace == EWSG_SPACE_PROG) && !extProgSel && accAddr[15]
      |=> waits_r == ($past(multBit_r) ? {$past(progHiBase), 1'b0} : {1'b0, $past(progHiBase)}))
      else $error("Upper program page access used wrong count.");
   prog_low_a: assert property (accept && (accSpace == EWSG_SPACE_PROG) && extProgSel && !accAddr[22]
      |=> waits_r == ($past(multBit_r) ? {$past(progLoBase), 1'b0} : {1'b0, $past(progLoBase)}))
      else $error("Lower extended program access used wrong count.");

   // Register port: a write lands at its strobe edge, and a read returns what stood before that edge.
   counts_write_a: assert property (mmrWr && hitCounts
      |=> counts_r == $past(mmrWrData))
      else $error("Counts register write lost.");
   counts_read_a: assert property (mmrRd && hitCounts
      |=> mmrRdData == $past(counts_r))
      else $error("Counts register read wrong.");
   ctrl_write_a: assert property (mmrWr && hitControl
      |=> {15'h0000, multBit_r} == ($past(mmrWrData) & 16'h0001))
      else $error("Control register write lost.");
   unmapped_read_a: assert property (mmrRd && !hitCounts && !hitControl
      |=> mmrRdData == 16'h0000)
      else $error("Unmapped register read not zero.");

   // Sequencing: a refused request leaves no trace, so a master must watch busy itself.
   wait_bound_a: assert property ((state_r == EWSG_ST_WAIT)
      |-> ##[1:14] (state_r == EWSG_ST_READY))
      else $error("Wait phase outlasted fourteen cycles.");
   zero_wait_a: assert property (accept && (reqWaits == 4'h0)
      |=> (state_r == EWSG_ST_READY))
      else $error("Zero-wait access did not go straight to ready.");
   busy_state_a: assert property (busy_r == (state_r != EWSG_ST_IDLE))
      else $error("Busy flag out of step with the access.");
   done_pulse_a: assert property (done_r
      |=> !done_r)
      else $error("Completion pulse longer than one cycle.");
   refuse_busy_a: assert property (accReq && busy_r
      |=> $stable(waits_r))
      else $error("Request taken while busy.");

   // The gate may only stop while bits 13:0 of the counts register are zero; I/O bit 14 is not looked at.
   clk_run_a: assert property (!allZero
      |=> clkEn_r)
      else $error("Wait clock stopped with a nonzero count.");
endmodule
`default_nettype wire

// File: hdl/ewsg_regs.svh
`ifndef EWSG_REGS_SVH
`define EWSG_REGS_SVH

// Register addresses on the memory-mapped register port.
`define EWSG_ADDR_COUNTS 7'h28
`define EWSG_ADDR_CONTROL 7'h2B

// Field positions inside the wait-state counts register.
`define EWSG_EXTPROG_BIT 15
`define EWSG_IO_LSB 12
`define EWSG_DHI_LSB 9
`define EWSG_DLO_LSB 6
`define EWSG_PHI_LSB 3
`define EWSG_PLO_LSB 0
`define EWSG_FIELD_W 3

// Multiplier bit position inside the control register.
`define EWSG_MULT_BIT 0

// Reset values.
`define EWSG_COUNTS_RESET 16'h7FFF
`define EWSG_CONTROL_RESET 16'h0000

// Largest number of inserted wait states.
`define EWSG_MAX_WAITS 4'hE

`endif

// File: hdl/ewsg_pkg.sv
`default_nettype none
package ewsg_pkg;

   typedef enum logic [1:0] {
      EWSG_SPACE_PROG = 2'b00,
      EWSG_SPACE_DATA = 2'b01,
      EWSG_SPACE_IO = 2'b10
   } ewsg_space_t;

   typedef enum logic [1:0] {
      EWSG_ST_IDLE = 2'b00,
      EWSG_ST_WAIT = 2'b01,
      EWSG_ST_READY = 2'b10
   } ewsg_state_t;

endpackage
`default_nettype wire

// File: hdl/ewsg_wait_counter.sv
`default_nettype none
module ewsg_wait_counter #(
   parameter int W = 4
) (
   input wire logic mclk, // Processor clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic cntEn, // Enable from the wait-state clock gate.
   input wire logic load, // Load a new count.
   input wire logic [W-1:0] loadVal, // Count to load.
   output logic lastOne // Count stands at one.
);
   logic [W-1:0] count_r;
   logic [W-1:0] count_nxt;

   assign count_nxt = load ? loadVal : ((count_r != '0) ? count_r - W'(1) : count_r);
   assign lastOne = (count_r == W'(1));

   // The enable stands in for the gated clock, so the counter freezes while counts bits 13:0 are zero and no access is in its wait phase.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= '0;
      end else if (cntEn || load) begin
         count_r <= count_nxt;
      end
   end
endmodule
`default_nettype wire

// File: dv/ewsg_ext_dev.sv
`default_nettype none
module ewsg_ext_dev (
   input wire logic mclk, // Processor clock.
   input wire logic rst_n, // Reset, active low.
   input wire logic accBusy, // Access in progress.
   input wire logic [3:0] slowCycles, // Extra cycles this device needs.
   output logic extReady // Ready back to the wait generator.
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] heldCnt_r;
   // A slow device keeps ready low for its first slowCycles cycles of an access, past the programmed count when that is smaller.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) heldCnt_r <= 5'h00;
      else heldCnt_r <= accBusy ? heldCnt_r + 5'h01 : 5'h00;
   end
   assign extReady = ({1'b0, slowCycles} <= heldCnt_r);
endmodule
`default_nettype wire

// File: dv/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import ewsg_pkg::*;
   logic mclk = 1'b0, rst_n = 1'b0, mmrWr = 1'b0, mmrRd = 1'b0, accReq = 1'b0;
   logic [6:0] mmrAddr = 7'h00;
   logic [15:0] mmrWrData = 16'h0000, mmrRdData, cnt, ctl;
   ewsg_space_t accSpace = EWSG_SPACE_PROG;
   logic [22:0] accAddr = 23'h000000;
   logic extReady, accBusy, accDone, waitGenClkEn;
   logic [3:0] accWaits, slowCycles = 4'h0;
   logic [31:0] rnd = 32'hA26E;
   int errors = 0, tests_run = 0, cycles = 0;
   always #50 mclk = ~mclk;
   ewsg_top i_ewsg_top (.mclk(mclk), .rst_n(rst_n), .mmrAddr(mmrAddr), .mmrWr(mmrWr), .mmrRd(mmrRd),
      .mmrWrData(mmrWrData), .mmrRdData(mmrRdData), .accReq(accReq), .accSpace(accSpace),
      .accAddr(accAddr), .extReady(extReady), .accBusy(accBusy), .accDone(accDone),
      .accWaits(accWaits), .waitGenClkEn(waitGenClkEn));
   ewsg_ext_dev i_ewsg_ext_dev (.mclk(mclk), .rst_n(rst_n), .accBusy(accBusy),
      .slowCycles(slowCycles), .extReady(extReady));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [3:0] expWaits(input logic [15:0] c, input logic m, input ewsg_space_t s,
      input logic [22:0] a);
      logic [2:0] b;
      b = (c[15] ? a[22] : a[15]) ? c[5:3] : c[2:0];
      if (s == EWSG_SPACE_DATA) b = a[15] ? c[11:9] : c[8:6];
      if (s == EWSG_SPACE_IO) b = c[14:12];
      return m ? {b, 1'b0} : {1'b0, b};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge mclk);
      #10 mmrAddr = a;
      mmrWrData = d;
      mmrWr = 1'b1;
      @(posedge mclk);
      #10 mmrWr = 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      @(posedge mclk);
      #10 mmrAddr = a;
      mmrRd = 1'b1;
      @(posedge mclk);
      #10 mmrRd = 1'b0;
      chk(mmrRdData, exp);
   endtask
   task automatic acc(input ewsg_space_t s, input logic [22:0] a);
      logic [3:0] n;
      int k;
      n = expWaits(cnt, ctl[0], s, a);
      k = 0;
      @(posedge mclk);
      #10 accSpace = s;
      accAddr = a;
      accReq = 1'b1;
      @(posedge mclk);
      #10 accReq = 1'b0;
      chk({11'h000, accBusy, accWaits}, {11'h000, 1'b1, n});
      do begin
         @(posedge mclk);
         #10 k++;
      end while (accDone !== 1'b1 && k < 40);
      chk({15'h0000, accBusy}, 16'h0000);
      if (slowCycles > n) chk(k[15:0], 16'(slowCycles) + 16'h0001);
      else chk(k[15:0], 16'(n) + 16'h0001);
   endtask
   // A hung handshake must still reach the verdict.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 6000) begin
         errors++;
         tally_and_finish;
      end
   end
   initial begin
      repeat (4) @(posedge mclk);
      #10 rst_n = 1'b1;
      cnt = 16'h7FFF;
      ctl = 16'h0000;
      chk({15'h0000, waitGenClkEn}, 16'h0001);
      rd(7'h28, 16'h7FFF);
      rd(7'h2B, 16'h0000);
      acc(EWSG_SPACE_IO, 23'h000000);
      acc(EWSG_SPACE_PROG, 23'h400000);
      wr(7'h2B, 16'hFFFF);
      ctl = 16'h0001;
      rd(7'h2B, 16'h0001);
      acc(EWSG_SPACE_DATA, 23'h008000);
      wr(7'h11, 16'h1234);
      rd(7'h11, 16'h0000);
      cnt = 16'h8038;
      wr(7'h28, cnt);
      acc(EWSG_SPACE_PROG, 23'h408000);
      acc(EWSG_SPACE_PROG, 23'h008000);
      for (int i = 0; i < 40; i++) begin
         rnd = lfsr(rnd);
         cnt = rnd[15:0];
         wr(7'h28, cnt);
         ctl = {15'h0000, rnd[16]};
         wr(7'h2B, rnd[31:16]);
         rd(7'h28, cnt);
         acc(ewsg_space_t'(rnd[1:0] % 2'h3), rnd[22:0]);
         rnd = lfsr(rnd);
         acc(ewsg_space_t'(rnd[1:0] % 2'h3), rnd[22:0]);
      end
      acc(ewsg_space_t'(2'b11), rnd[22:0]);
      // A second reset in mid-run must bring every count back to seven.
      rst_n = 1'b0;
      @(posedge mclk);
      #10 rst_n = 1'b1;
      cnt = 16'h7FFF;
      ctl = 16'h0000;
      rd(7'h28, 16'h7FFF);
      rd(7'h2B, 16'h0000);
      acc(EWSG_SPACE_DATA, 23'h000000);
      // A request held for the first three cycles of the access must not be taken again while busy.
      @(posedge mclk);
      #10 accSpace = EWSG_SPACE_IO;
      accReq = 1'b1;
      repeat (3) @(posedge mclk);
      #10 accReq = 1'b0;
      repeat (6) @(posedge mclk);
      #10 chk({11'h000, accDone, accWaits}, {11'h000, 1'b1, 4'h7});
      cnt = 16'h8000;
      wr(7'h28, cnt);
      @(posedge mclk);
      #10 chk({15'h0000, waitGenClkEn}, 16'h0000);
      acc(EWSG_SPACE_PROG, 23'h000000);
      cnt = 16'h7FFF;
      wr(7'h28, cnt);
      slowCycles = 4'hF;
      acc(EWSG_SPACE_IO, 23'h000000);
      tally_and_finish;
   end
endmodule
`default_nettype wire
